// >>> core/protect_area_decoder.sv
// Block-protect area decoder for one sector index
`timescale 1ns/1ps
`default_nettype none

module protect_area_decoder #(
    parameter int SECT_BITS = 7
) (
    // Protect setting
    input wire logic [3:0] protectCode,
    input wire logic areaBottomSelect,
    // Sector under test
    input wire logic [SECT_BITS-1:0] sector,
    output logic protectedHit
);

    logic [SECT_BITS:0] span;
    logic [SECT_BITS:0] sectWide;
    logic [SECT_BITS:0] total;

    assign total = (SECT_BITS+1)'(1) << SECT_BITS;
    assign sectWide = {1'b0, sector};

    always_comb begin
        if (protectCode == 4'h0) begin
            span = '0;
        end else if (protectCode[3]) begin
            span = total;
        end else begin
            span = (SECT_BITS+1)'(1) << (protectCode[2:0] - 3'h1);
        end
        if (areaBottomSelect) begin
            protectedHit = sectWide < span; // [R9]
        end else begin
            protectedHit = (span != '0) && (sectWide >= total - span); // [R8]
        end
    end

endmodule // protect_area_decoder

`default_nettype wire

// >>> core/serial_flash_write_protection.sv
// Write-protection checker for a serial flash command stream
//
// Notes on behaviour
// R1: Refuse modify commands on partial-byte frames
// R2: Modifying commands need the write-enable latch set
// R3: No modification before supply-valid timer expires
// R4: Write-locked sector rejects program and erase
// R5: Unlocked-down sector lock bit changes freely
// R6: Lock-down freezes lock until reset; the code also clears it on a CTRL_LOCK_CLR write to the control register
// R7: Lock write refused when sector locked down
// R8: Bottom-select 0 protects highest sectors by code
// R9: Bottom-select 1 protects lowest sectors by code
// R10: Sector index from address bits 22 to 16
// R11: Low write-protect pin freezes protect bits
// R12: Execute only outside protect area and locks
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "flash_wp_params.svh"

module serial_flash_write_protection #(
    parameter int NUM_SECTORS = 128,
    parameter int SECT_BITS = 7,
    parameter int PWR_CYCLES = `PWR_VALID_CYCLES
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Serial link
    input wire logic sckClk,
    input wire logic selectN,
    input wire logic dataIn,
    input wire logic writeProtectN,
    // Command verdicts
    output logic grantValid,
    output logic [7:0] grantCmd,
    output logic [23:0] grantAddr,
    output logic rejectValid,
    output logic writeEnableLatch
);

    // ------------------------------------------------------------------------
    // Link domain: frame capture
    // ------------------------------------------------------------------------
    logic [2:0] bitCnt_reg;
    logic [2:0] byteCnt_reg;
    logic [6:0] shift_reg;
    logic [7:0] op_reg;
    logic [23:0] addr_reg;
    logic [7:0] data_reg;
    logic whole_reg;
    logic [2:0] bytes_reg;
    logic frameTog_reg;
    logic byteDone;
    logic [7:0] newByte;

    assign byteDone = bitCnt_reg == `BIT_LAST;
    assign newByte = {shift_reg, dataIn};

    always_ff @(posedge sckClk or posedge selectN) begin
        if (selectN) begin
            bitCnt_reg <= '0;
            byteCnt_reg <= '0;
            shift_reg <= '0;
        end else begin
            bitCnt_reg <= bitCnt_reg + 3'h1;
            shift_reg <= newByte[6:0];
            if (byteDone && byteCnt_reg != `BYTES_SAT) begin
                byteCnt_reg <= byteCnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge sckClk or negedge rst_n) begin
        if (!rst_n) begin
            op_reg <= '0;
            addr_reg <= '0;
            data_reg <= '0;
            whole_reg <= 1'b0;
            bytes_reg <= '0;
            frameTog_reg <= 1'b0;
        end else begin
            whole_reg <= byteDone; // [R1]
            if (byteDone && byteCnt_reg != `BYTES_SAT) begin
                bytes_reg <= byteCnt_reg + 3'h1;
            end else begin
                bytes_reg <= byteCnt_reg;
            end
            if (bitCnt_reg == '0 && byteCnt_reg == `BYTES_NONE) begin
                frameTog_reg <= ~frameTog_reg;
            end
            if (byteDone) begin
                case (byteCnt_reg)
                    3'h0: op_reg <= newByte;
                    3'h1: addr_reg[23:16] <= newByte;
                    3'h2: addr_reg[15:8] <= newByte;
                    3'h3: addr_reg[7:0] <= newByte;
                    3'h4: data_reg <= newByte;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Crossing into the system domain
    // ------------------------------------------------------------------------
    logic selSync1, selSync2, selSync3;
    logic togSync1, togSync2, togSeen;
    logic wpSync1, wpSync2;
    logic frameEnd;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            selSync1 <= 1'b1;
            selSync2 <= 1'b1;
            selSync3 <= 1'b1;
            togSync1 <= 1'b0;
            togSync2 <= 1'b0;
            wpSync1 <= 1'b1;
            wpSync2 <= 1'b1;
        end else begin
            selSync1 <= selectN;
            selSync2 <= selSync1;
            selSync3 <= selSync2;
            togSync1 <= frameTog_reg;
            togSync2 <= togSync1;
            wpSync1 <= writeProtectN;
            wpSync2 <= wpSync1;
        end
    end

    assign frameEnd = selSync2 && !selSync3 && (togSync2 != togSeen);

    // Frame fields are static once deselect has been seen
    logic evalPend;
    logic [7:0] capOp;
    logic [23:0] capAddr;
    logic [7:0] capData;
    logic capWhole;
    logic [2:0] capBytes;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            togSeen <= 1'b0;
            evalPend <= 1'b0;
            capOp <= '0;
            capAddr <= '0;
            capData <= '0;
            capWhole <= 1'b0;
            capBytes <= '0;
        end else begin
            evalPend <= frameEnd;
            if (frameEnd) begin
                togSeen <= togSync2;
                capOp <= op_reg;
                capAddr <= addr_reg;
                capData <= data_reg;
                capWhole <= whole_reg;
                capBytes <= bytes_reg;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Supply-valid timer
    // ------------------------------------------------------------------------
    logic [$clog2(PWR_CYCLES+1)-1:0] pwrCnt_reg;
    logic pwrOk_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwrCnt_reg <= '0;
            pwrOk_reg <= 1'b0;
        end else if (!pwrOk_reg) begin
            pwrCnt_reg <= pwrCnt_reg + 1'b1;
            pwrOk_reg <= pwrCnt_reg == ($clog2(PWR_CYCLES+1))'(PWR_CYCLES - 1); // [R3]
        end
    end

    // ------------------------------------------------------------------------
    // Protection state and verdict
    // ------------------------------------------------------------------------
    logic [NUM_SECTORS-1:0] writeLock;
    logic [NUM_SECTORS-1:0] lockDown;
    logic [3:0] protectCode_reg;
    logic areaBottomSelect_reg;
    logic wel_reg;
    logic lockClr;
    logic areaHit;
    logic [SECT_BITS-1:0] sector;
    flash_wp_pkg::verdict_e verdict;
    logic [2:0] needBytes;
    logic isModify;
    logic lockGo;

    assign sector = capAddr[`SECTOR_MSB:`SECTOR_LSB]; // [R10]

    protect_area_decoder #(
        .SECT_BITS(SECT_BITS)
    ) areaDecode (
        .protectCode(protectCode_reg),
        .areaBottomSelect(areaBottomSelect_reg),
        .sector(sector),
        .protectedHit(areaHit)
    );

    always_comb begin
        isModify = 1'b1;
        needBytes = `BYTES_CMD;
        case (capOp)
            flash_wp_pkg::CMD_PROGRAM: needBytes = `BYTES_DATA;
            flash_wp_pkg::CMD_WR_LOCK: needBytes = `BYTES_DATA;
            flash_wp_pkg::CMD_SECT_ERASE: needBytes = `BYTES_ADDR;
            flash_wp_pkg::CMD_SUBSECT_ERASE: needBytes = `BYTES_ADDR;
            flash_wp_pkg::CMD_WR_STATUS: needBytes = `BYTES_REG;
            flash_wp_pkg::CMD_BULK_ERASE: needBytes = `BYTES_CMD;
            default: isModify = 1'b0;
        endcase
        verdict = flash_wp_pkg::VERDICT_OK;
        if (!isModify && capOp != flash_wp_pkg::CMD_WR_ENABLE
                && capOp != flash_wp_pkg::CMD_WR_DISABLE) begin
            verdict = flash_wp_pkg::VERDICT_UNKNOWN;
        end else if (isModify && !pwrOk_reg) begin
            verdict = flash_wp_pkg::VERDICT_POWER; // [R3]
        end else if (!capWhole || capBytes < needBytes) begin
            verdict = flash_wp_pkg::VERDICT_NOT_WHOLE; // [R1]
        end else if (isModify && !wel_reg) begin
            verdict = flash_wp_pkg::VERDICT_NO_WEL; // [R2]
        end else if (capOp == flash_wp_pkg::CMD_WR_STATUS && !wpSync2) begin
            verdict = flash_wp_pkg::VERDICT_FROZEN; // [R11]
        end else if (capOp == flash_wp_pkg::CMD_WR_LOCK && lockDown[sector]) begin
            verdict = flash_wp_pkg::VERDICT_LOCKED; // [R7]
        end else if (capOp == flash_wp_pkg::CMD_BULK_ERASE) begin
            if (protectCode_reg != 4'h0 || |writeLock) begin
                verdict = flash_wp_pkg::VERDICT_AREA; // [R12]
            end
        end else if (capOp == flash_wp_pkg::CMD_PROGRAM
                || capOp == flash_wp_pkg::CMD_SECT_ERASE
                || capOp == flash_wp_pkg::CMD_SUBSECT_ERASE) begin
            if (writeLock[sector]) begin
                verdict = flash_wp_pkg::VERDICT_LOCKED; // [R4]
            end else if (areaHit) begin
                verdict = flash_wp_pkg::VERDICT_AREA; // [R12]
            end
        end
    end

    assign lockGo = evalPend && verdict == flash_wp_pkg::VERDICT_OK
        && capOp == flash_wp_pkg::CMD_WR_LOCK; // [R7]

    genvar i;
    generate
        for (i = 0; i < NUM_SECTORS; i++) begin : gLock
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    writeLock[i] <= 1'b0;
                    lockDown[i] <= 1'b0;
                end else if (lockGo && sector == SECT_BITS'(i)) begin
                    writeLock[i] <= capData[`LOCK_WRITE_BIT]; // [R5]
                    lockDown[i] <= lockDown[i] | capData[`LOCK_DOWN_BIT]; // [R6]
                end else if (lockClr) begin
                    writeLock[i] <= 1'b0; // [R6]
                    lockDown[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wel_reg <= 1'b0;
            protectCode_reg <= '0;
            areaBottomSelect_reg <= 1'b0;
        end else if (evalPend && verdict == flash_wp_pkg::VERDICT_OK) begin
            if (capOp == flash_wp_pkg::CMD_WR_ENABLE) begin
                wel_reg <= 1'b1; // [R2]
            end else begin
                wel_reg <= 1'b0;
            end
            if (capOp == flash_wp_pkg::CMD_WR_STATUS) begin
                protectCode_reg <= capAddr[`STAT_BYTE_LSB+`DATA_CODE_MSB:`STAT_BYTE_LSB]; // [R11]
                areaBottomSelect_reg <= capAddr[`STAT_BYTE_LSB+`DATA_BOTTOM];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Verdict outputs
    // ------------------------------------------------------------------------
    logic [7:0] lastOp_reg;
    flash_wp_pkg::verdict_e lastVerdict_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            grantValid <= 1'b0;
            grantCmd <= '0;
            grantAddr <= '0;
            rejectValid <= 1'b0;
            lastOp_reg <= '0;
            lastVerdict_reg <= flash_wp_pkg::VERDICT_OK;
        end else begin
            grantValid <= evalPend && verdict == flash_wp_pkg::VERDICT_OK
                && (capOp == flash_wp_pkg::CMD_PROGRAM
                || capOp == flash_wp_pkg::CMD_SECT_ERASE
                || capOp == flash_wp_pkg::CMD_SUBSECT_ERASE
                || capOp == flash_wp_pkg::CMD_BULK_ERASE); // [R12]
            rejectValid <= evalPend && verdict != flash_wp_pkg::VERDICT_OK;
            if (evalPend) begin
                grantCmd <= capOp;
                grantAddr <= capAddr;
                lastOp_reg <= capOp;
                lastVerdict_reg <= verdict;
            end
        end
    end

    assign writeEnableLatch = wel_reg;

    // ------------------------------------------------------------------------
    // Avalon-MM register slave
    // ------------------------------------------------------------------------
    logic [SECT_BITS-1:0] sectSel_reg;
    logic [31:0] readMux;
    logic wrGo;

    assign wrGo = write && !waitrequest;
    assign lockClr = wrGo && address == `REG_CTRL && writedata[`CTRL_LOCK_CLR];

    always_comb begin
        readMux = '0;
        case (address)
            `REG_STATUS: begin
                readMux[`ST_WEL] = wel_reg;
                readMux[`ST_CODE_MSB:`ST_CODE_LSB] = protectCode_reg;
                readMux[`ST_BOTTOM] = areaBottomSelect_reg;
                readMux[`ST_PWR_OK] = pwrOk_reg;
                readMux[`ST_WP_PIN] = wpSync2;
            end
            `REG_SECT_SEL: readMux[SECT_BITS-1:0] = sectSel_reg;
            `REG_SECT_LOCK: begin
                readMux[`LOCK_WRITE_BIT] = writeLock[sectSel_reg];
                readMux[`LOCK_DOWN_BIT] = lockDown[sectSel_reg];
            end
            `REG_LAST_CMD: begin
                readMux[`LAST_OP_MSB:0] = lastOp_reg;
                readMux[`LAST_VERDICT_LSB+2:`LAST_VERDICT_LSB] = lastVerdict_reg;
            end
            default: readMux = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata <= '0;
            sectSel_reg <= '0;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                readdata <= readMux;
            end
            if (wrGo && address == `REG_SECT_SEL) begin
                sectSel_reg <= writedata[SECT_BITS-1:0];
            end
        end
    end

endmodule // serial_flash_write_protection

`default_nettype wire

// >>> dv/serial_flash_write_protection_monitor.sv
// Port-level assertions for the write-protection block
`timescale 1ns/1ps
`default_nettype none

module serial_flash_write_protection_monitor #(
    parameter int PWR_CYCLES = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register bus
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // Verdicts
    input wire logic grantValid,
    input wire logic [7:0] grantCmd,
    input wire logic rejectValid,
    input wire logic writeEnableLatch
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------------
    // Cycles since reset release, saturating
    // ------------------------------------------------------------------------
    int upCnt;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            upCnt <= 0;
        end else if (upCnt < PWR_CYCLES) begin
            upCnt <= upCnt + 1;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered in one cycle");
    chk_wait_release: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_power_hold: assert property (grantValid |-> upCnt >= PWR_CYCLES - 2)
        else $error("grant before supply valid time");
    chk_grant_wel: assert property (grantValid |-> $past(writeEnableLatch) && !writeEnableLatch)
        else $error("grant without write enable or latch not cleared");
    chk_reject_wel: assert property (rejectValid |-> $stable(writeEnableLatch))
        else $error("refused command changed write enable");
    chk_pulse_excl: assert property (!(grantValid && rejectValid))
        else $error("grant and reject together");
    chk_grant_single: assert property (grantValid ##1 1'b1 |-> !grantValid)
        else $error("grant longer than one cycle");
    chk_reject_single: assert property ($rose(rejectValid) |=> $fell(rejectValid))
        else $error("reject longer than one cycle");
    chk_grant_ops: assert property (grantValid |-> grantCmd inside {8'h02, 8'hd8, 8'h20, 8'hc7})
        else $error("grant for a non-array command");
endmodule // serial_flash_write_protection_monitor

`default_nettype wire

// >>> dv/serial_flash_write_protection_tb.sv
// Self-checking bench for the write-protection block
`timescale 1ns/1ps
`default_nettype none

module serial_flash_write_protection_tb;
    localparam int PWR = 600;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic sckClk;
    logic selectN;
    logic dataIn;
    logic writeProtectN = 1'b1;
    logic grantValid;
    logic [7:0] grantCmd;
    logic [23:0] grantAddr;
    logic rejectValid;
    logic writeEnableLatch;
    logic [31:0] rdVal;
    int err_total = 0;
    int cmp_count = 0;

    always #2.5 ref_clk = ~ref_clk;

    spi_host_model host_u (.sckClk(sckClk), .selectN(selectN), .dataIn(dataIn));

    serial_flash_write_protection #(.PWR_CYCLES(PWR)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .sckClk(sckClk), .selectN(selectN), .dataIn(dataIn), .writeProtectN(writeProtectN),
        .grantValid(grantValid), .grantCmd(grantCmd), .grantAddr(grantAddr),
        .rejectValid(rejectValid), .writeEnableLatch(writeEnableLatch)
    );

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rdVal = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) begin
            err_total++;
            wrap_up();
        end
    endtask

    task automatic frame(input logic [39:0] d, input int nbits, input logic gExp, input int vExp);
        logic sawG = 1'b0;
        logic sawR = 1'b0;
        host_u.send(d, nbits, 24);
        repeat (12) begin
            @(posedge ref_clk);
            if (grantValid === 1'b1) begin
                sawG = 1'b1;
                check("grant opcode", grantCmd, d[39:32]);
                if (nbits >= 32) begin
                    check("grant address", grantAddr, d[31:8]);
                end
            end
            sawR = sawR | (rejectValid === 1'b1);
        end
        check("grant pulse", sawG, gExp);
        check("reject pulse", sawR, vExp != 0);
        bus(1'b0, 5'h10, 32'h0);
        if (vExp >= 0) begin
            check("verdict", rdVal[10:8], vExp[2:0]);
        end
    endtask

    task automatic wren();
        frame({8'h06, 32'h0}, 8, 1'b0, 0);
    endtask

    task automatic erase(input logic [6:0] s, input int v);
        wren();
        frame({8'hd8, 1'b0, s, 16'hf000, 8'h00}, 32, v == 0, v);
    endtask

    task automatic setcode(input logic b, input logic [3:0] c, input int v);
        wren();
        frame({8'h01, 3'h0, b, c, 24'h0}, 16, 1'b0, v);
    endtask

    task automatic lockwr(input logic [6:0] s, input logic dn, input logic lk, input int v);
        wren();
        frame({8'he5, 1'b0, s, 16'h0, 6'h0, dn, lk}, 40, 1'b0, v);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic power_scen();
        bus(1'b0, 5'h00, 32'h0);
        check("status at reset", rdVal[6:0], 7'h00);
        frame({8'h02, 24'h010000, 8'h5a}, 40, 1'b0, 3);
        bus(1'b0, 5'h00, 32'h0);
        check("supply valid early", rdVal[6], 1'b0);
        repeat (PWR) @(posedge ref_clk);
        bus(1'b0, 5'h00, 32'h0);
        check("supply valid late", rdVal[6], 1'b1);
    endtask

    task automatic frame_scen();
        frame({8'h02, 24'h020000, 8'h5a}, 40, 1'b0, 2);
        wren();
        check("latch set", writeEnableLatch, 1'b1);
        frame({8'h02, 24'h020000, 8'h5a}, 39, 1'b0, 1);
        frame({8'h01, 32'h0}, 8, 1'b0, 1);
        frame({8'h03, 32'h0}, 8, 1'b0, 7);
        check("latch kept", writeEnableLatch, 1'b1);
        frame({8'h04, 32'h0}, 8, 1'b0, 0);
        check("latch cleared", writeEnableLatch, 1'b0);
    endtask

    task automatic area_scen();
        int n;
        for (int b = 0; b < 2; b++) begin
            for (int c = 0; c < 16; c++) begin
                n = (c == 0) ? 0 : ((c < 8) ? (1 << (c - 1)) : 128);
                setcode(b[0], c[3:0], 0);
                erase(b ? 7'(n - 1) : 7'(128 - n), (n > 0) ? 5 : 0);
                erase(b ? 7'(n) : 7'(127 - n), (n == 128) ? 5 : 0);
            end
        end
        setcode(1'b0, 4'h0, 0);
        wren();
        frame({8'hc7, 32'h0}, 8, 1'b1, 0);
    endtask

    task automatic lock_scen();
        lockwr(7'd5, 1'b0, 1'b1, 0);
        bus(1'b1, 5'h08, 32'h5);
        bus(1'b0, 5'h08, 32'h0);
        check("sector select", rdVal, 32'h5);
        bus(1'b0, 5'h0c, 32'h0);
        check("lock bits", rdVal, 32'h1);
        erase(7'd5, 4);
        wren();
        frame({8'h20, 8'h06, 16'hf000, 8'h00}, 32, 1'b1, 0);
        lockwr(7'd5, 1'b0, 1'b0, 0);
        wren();
        frame({8'h02, 24'h050010, 8'h5a}, 40, 1'b1, 0);
        lockwr(7'd5, 1'b1, 1'b1, 0);
        wren();
        frame({8'hc7, 32'h0}, 8, 1'b0, 5);
        lockwr(7'd5, 1'b0, 1'b0, 4);
        bus(1'b0, 5'h0c, 32'h0);
        check("lock frozen", rdVal, 32'h3);
        erase(7'd5, 4);
        bus(1'b1, 5'h04, 32'h1);
        bus(1'b0, 5'h0c, 32'h0);
        check("lock cleared", rdVal, 32'h0);
        erase(7'd5, 0);
    endtask

    task automatic wp_scen();
        writeProtectN <= 1'b0;
        setcode(1'b0, 4'h3, 6);
        bus(1'b0, 5'h00, 32'h0);
        check("status under pin", rdVal, 32'h41);
        writeProtectN <= 1'b1;
        setcode(1'b1, 4'h2, 0);
        bus(1'b0, 5'h00, 32'h0);
        check("status after pin", rdVal, 32'he4);
        setcode(1'b0, 4'h0, 0);
        bus(1'b0, 5'h14, 32'h0);
        check("unmapped read", rdVal, 32'h0);
        bus(1'b0, 5'h04, 32'h0);
        check("control read", rdVal, 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        power_scen();
        frame_scen();
        area_scen();
        lock_scen();
        wp_scen();
        wrap_up();
    end
endmodule // serial_flash_write_protection_tb

bind serial_flash_write_protection serial_flash_write_protection_monitor #(
    .PWR_CYCLES(PWR_CYCLES)
) mon_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .read(read), .write(write),
    .waitrequest(waitrequest), .grantValid(grantValid), .grantCmd(grantCmd),
    .rejectValid(rejectValid), .writeEnableLatch(writeEnableLatch)
);

`default_nettype wire

// >>> dv/spi_host_model.sv
// Serial host model sending command frames on the link
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    // Link
    output var logic sckClk,
    output var logic selectN,
    output var logic dataIn
);
    initial begin
        sckClk = 1'b0;
        selectN = 1'b1;
        dataIn = 1'b0;
    end

    // Sends nbits of d MSB first; clock idles low, data toggles when released
    task automatic send(input logic [39:0] d, input int nbits, input int half);
        #7;
        selectN = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            dataIn = d[39 - i];
            #(half);
            sckClk = 1'b1;
            #(half);
            sckClk = 1'b0;
        end
        #(half);
        selectN = 1'b1;
        dataIn = ~dataIn;
    endtask
endmodule // spi_host_model

`default_nettype wire

// >>> pkg/flash_wp_params.svh
// Offsets, field positions and timing constants of the write-protection block
`ifndef FLASH_WP_PARAMS_SVH
`define FLASH_WP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define REG_STATUS 5'h00
`define REG_CTRL 5'h04
`define REG_SECT_SEL 5'h08
`define REG_SECT_LOCK 5'h0c
`define REG_LAST_CMD 5'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ST_WEL 0
`define ST_CODE_LSB 1
`define ST_CODE_MSB 4
`define ST_BOTTOM 5
`define ST_PWR_OK 6
`define ST_WP_PIN 7
`define CTRL_LOCK_CLR 0
`define DATA_CODE_MSB 3
`define DATA_BOTTOM 4
`define STAT_BYTE_LSB 16
`define LOCK_WRITE_BIT 0
`define LOCK_DOWN_BIT 1
`define LAST_OP_MSB 7
`define LAST_VERDICT_LSB 8
`define SECTOR_MSB 22
`define SECTOR_LSB 16

// ----------------------------------------------------------------------------
// Frame last-bit index and byte counts
// ----------------------------------------------------------------------------
`define BIT_LAST 3'h7
`define BYTES_SAT 3'h5
`define BYTES_NONE 3'h0
`define BYTES_CMD 3'h1
`define BYTES_REG 3'h2
`define BYTES_ADDR 3'h4
`define BYTES_DATA 3'h5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define PWR_VALID_NS 150000
`define PWR_VALID_CYCLES (`PWR_VALID_NS / `CLK_PERIOD_NS)

`endif

// >>> pkg/flash_wp_pkg.sv
// Command and verdict types of the write-protection block
package flash_wp_pkg;

    typedef enum logic [7:0] {
        CMD_WR_ENABLE = 8'h06,
        CMD_WR_DISABLE = 8'h04,
        CMD_PROGRAM = 8'h02,
        CMD_SECT_ERASE = 8'hd8,
        CMD_SUBSECT_ERASE = 8'h20,
        CMD_BULK_ERASE = 8'hc7,
        CMD_WR_STATUS = 8'h01,
        CMD_WR_LOCK = 8'he5
    } cmd_e;

    typedef enum logic [2:0] {
        VERDICT_OK = 3'b000,
        VERDICT_NOT_WHOLE = 3'b001,
        VERDICT_NO_WEL = 3'b010,
        VERDICT_POWER = 3'b011,
        VERDICT_LOCKED = 3'b100,
        VERDICT_AREA = 3'b101,
        VERDICT_FROZEN = 3'b110,
        VERDICT_UNKNOWN = 3'b111
    } verdict_e;

endpackage
